// file: dmm_regs.svh
`ifndef DMM_REGS_SVH
`define DMM_REGS_SVH

// Opcodes of the four instructions this unit executes
`define DMM_OPC_QCONST 8'hA1
`define DMM_OPC_MREG   8'hA2
`define DMM_OPC_MCONST 8'hA3
`define DMM_OPC_MAC    8'hA4

// Instruction field positions
`define DMM_OPC_LSB  24
`define DMM_SIZE_LSB 22
`define DMM_SIMD_BIT 21
`define DMM_REMF_BIT 20
`define DMM_SIGN_BIT 19
`define DMM_HIGH_BIT 18
`define DMM_IMM_LSB  12

// APB register byte addresses
`define DMM_A_CTRL 12'h000
`define DMM_A_STAT 12'h004
`define DMM_A_FCNT 12'h008

// Reset value of the control register: unit enabled, no saturation
`define DMM_CTRL_RST 2'h1

`endif

// file: dmm_pkg.sv
package dmm_pkg;

	// Main sequencer states, one-hot
	typedef enum logic [4:0] {
		DMM_IDLE  = 5'h01,
		DMM_LOAD  = 5'h02,
		DMM_DIV   = 5'h04,
		DMM_STORE = 5'h08,
		DMM_MAC   = 5'h10
	} dmm_state_t;

	// Divider states, one-hot
	typedef enum logic [1:0] {
		DMM_DV_IDLE = 2'h1,
		DMM_DV_RUN  = 2'h2
	} dmm_dv_state_t;

	// Lane mask for size code 0..3 (8, 16, 32, 64 bits)
	function automatic logic [63:0] dmm_mask(input logic [1:0] sz);
		case (sz)
		2'h0: dmm_mask = 64'h0000_0000_0000_00FF;
		2'h1: dmm_mask = 64'h0000_0000_0000_FFFF;
		2'h2: dmm_mask = 64'h0000_0000_FFFF_FFFF;
		default: dmm_mask = 64'hFFFF_FFFF_FFFF_FFFF;
		endcase
	endfunction : dmm_mask

	// Sign extension of the low lane to 64 bits
	function automatic logic [63:0] dmm_sext(input logic [63:0] x,
		input logic [1:0] sz);
		case (sz)
		2'h0: dmm_sext = {{56{x[7]}}, x[7:0]};
		2'h1: dmm_sext = {{48{x[15]}}, x[15:0]};
		2'h2: dmm_sext = {{32{x[31]}}, x[31:0]};
		default: dmm_sext = x;
		endcase
	endfunction : dmm_sext

endpackage : dmm_pkg

// file: dmm_div.sv
module dmm_div (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        start,
	input  wire logic [1:0]  sz,
	input  wire logic [63:0] dividend,
	input  wire logic [63:0] divisor,
	output logic             done,
	output logic [63:0]      quotient,
	output logic [63:0]      remainder
);
	import dmm_pkg::*;

	typedef struct packed {
		dmm_dv_state_t st;
		logic [6:0]    cnt;
		logic [63:0]   quo;
		logic [63:0]   rem;
		logic [63:0]   dvs;
		logic          done;
	} dmm_dv_t;

	dmm_dv_t     s;
	dmm_dv_t     next_s;
	logic [64:0] shifted;
	logic [64:0] diff;

	// Restoring divider, one quotient bit a cycle, so latency grows with size
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		shifted = {s.rem, s.quo[63]};
		diff = shifted - {1'b0, s.dvs};
		case (s.st)
		DMM_DV_IDLE: if (start) begin
			next_s.st = DMM_DV_RUN;
			next_s.cnt = 7'h08 << sz;
			// Align dividend to the top so bit 63 feeds each step
			next_s.quo = dividend << (7'h40 - (7'h08 << sz));
			next_s.rem = 64'h0;
			next_s.dvs = divisor;
		end
		DMM_DV_RUN: begin
			next_s.quo = {s.quo[62:0], ~diff[64]};
			next_s.rem = diff[64] ? shifted[63:0] : diff[63:0];
			next_s.cnt = s.cnt - 7'h01;
			if (s.cnt == 7'h01) begin
				next_s.st = DMM_DV_IDLE;
				next_s.done = 1'b1;
			end
		end
		default: next_s.st = DMM_DV_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.st <= DMM_DV_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
	assign quotient = s.quo;
	assign remainder = s.rem;

endmodule : dmm_div

// file: dmm_mac.sv
module dmm_mac (
	input  wire logic [1:0]  sz,
	input  wire logic        simd,
	input  wire logic        high,
	input  wire logic        sgn,
	input  wire logic [63:0] src2,
	input  wire logic [63:0] src3,
	input  wire logic [63:0] acc,
	output logic [63:0]      sum
);
	import dmm_pkg::*;

	logic [63:0] xa;
	logic [63:0] xb;
	logic [63:0] pa;
	logic [63:0] pb;
	logic [1:0]  csz;

	// One accumulate chunk; destination lane is twice the source size, 64 bits for size code 3
	always_comb begin
		csz = (sz == 2'h3) ? 2'h3 : sz + 2'h1;
		xa = src2;
		xb = src3;
		if (simd && high && sz != 2'h3) begin
			xa = src2 >> (7'h08 << sz);
			xb = src3 >> (7'h08 << sz);
		end
		pa = sgn ? dmm_sext(xa, sz) : (xa & dmm_mask(sz));
		pb = sgn ? dmm_sext(xb, sz) : (xb & dmm_mask(sz));
		// Wraps silently: overflow is left to the issuing software
		sum = (acc + pa * pb) & dmm_mask(csz);
	end

endmodule : dmm_mac

// file: dmm_unit.sv
// Local design decisions: the register addresses and the APB register port.
`include "dmm_regs.svh"

module dmm_unit (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        issue_valid,
	input  wire logic [31:0] issue_instr,
	input  wire logic [63:0] issue_src2,
	input  wire logic [63:0] issue_src3,
	input  wire logic [63:0] issue_dst_val,
	output logic             issue_ready,
	output logic             wr_valid,
	output logic [5:0]       wr_dest,
	output logic [63:0]      wr_data,
	output logic             wr2_valid,
	output logic [5:0]       wr2_dest,
	output logic [63:0]      wr2_data,
	output logic             fault_valid,
	output logic [31:0]      fault_instr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	import dmm_pkg::*;

	typedef struct packed {
		dmm_state_t  st;
		logic [31:0] ins;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] acc;
		logic [2:0]  k;
		logic [63:0] resq;
		logic [63:0] resr;
		logic        negq;
		logic        negr;
		logic        satl;
		logic        div_start;
		logic        ctrl_en;
		logic        ctrl_sat;
		logic        last_fault;
		logic [15:0] fault_cnt;
		logic        issue_ready;
		logic        wr_valid;
		logic [5:0]  wr_dest;
		logic [63:0] wr_data;
		logic        wr2_valid;
		logic [5:0]  wr2_dest;
		logic [63:0] wr2_data;
		logic        fault_valid;
		logic [31:0] fault_instr;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dmm_unit_t;

	dmm_unit_t   s;
	dmm_unit_t   next_s;
	logic [7:0]  opc;
	logic [1:0]  sz;
	logic [1:0]  lsz;
	logic        simd;
	logic        sgn;
	logic        is_mac;
	logic        is_mreg;
	logic [6:0]  sh;
	logic [63:0] msk;
	logic [63:0] lmsk;
	logic        last;
	logic [63:0] dvd_lane;
	logic [63:0] dvs_lane;
	logic [63:0] xd;
	logic [63:0] xv;
	logic        na;
	logic        nb;
	logic [63:0] abs_d;
	logic [63:0] abs_v;
	logic        div_done;
	logic [63:0] div_q;
	logic [63:0] div_r;
	logic [63:0] mac_sum;
	logic [63:0] q_l;
	logic [63:0] r_l;
	logic        fin;
	logic        take;

	// Field decode of the held instruction
	assign opc = s.ins[`DMM_OPC_LSB +: 8];
	assign sz = s.ins[`DMM_SIZE_LSB +: 2];
	assign simd = s.ins[`DMM_SIMD_BIT];
	assign is_mac = opc == `DMM_OPC_MAC;
	assign is_mreg = opc == `DMM_OPC_MREG;
	// Constant forms divide signed since the constant is sign-extended
	assign sgn = (is_mac || is_mreg) ? s.ins[`DMM_SIGN_BIT] : 1'b1;
	// Accumulate chunks are twice the source lane, except 64-bit lanes stay 64 bits
	assign lsz = (is_mac && sz != 2'h3) ? sz + 2'h1 : sz;
	assign sh = {4'h0, s.k} << (3'h3 + {1'b0, lsz});
	assign msk = dmm_mask(sz);
	assign lmsk = dmm_mask(lsz);
	assign last = s.k == (simd ? (3'h7 >> lsz) : 3'h0);

	// Operand lanes: register modulo takes third mod second operand
	assign dvd_lane = ((is_mreg ? s.b : s.a) >> sh) & msk;
	assign dvs_lane = is_mreg ? ((s.a >> sh) & msk)
		: (dmm_sext({56'h0, s.ins[`DMM_IMM_LSB +: 8]}, 2'h0) & msk);
	assign xd = dmm_sext(dvd_lane, sz);
	assign xv = dmm_sext(dvs_lane, sz);
	assign na = sgn & xd[63];
	assign nb = sgn & xv[63];
	assign abs_d = na ? ((64'h0 - xd) & msk) : dvd_lane;
	assign abs_v = nb ? ((64'h0 - xv) & msk) : dvs_lane;

	// Shared divide engine for quotient and remainder forms
	dmm_div u_div (
		.clock     (clock),
		.arst_n    (arst_n),
		.start     (s.div_start),
		.sz        (sz),
		.dividend  (abs_d),
		.divisor   (abs_v),
		.done      (div_done),
		.quotient  (div_q),
		.remainder (div_r)
	);

	// One accumulate chunk per cycle; all three operands read here
	dmm_mac u_mac (
		.sz   (sz),
		.simd (simd),
		.high (s.ins[`DMM_HIGH_BIT]),
		.sgn  (s.ins[`DMM_SIGN_BIT]),
		.src2 (s.a >> sh),
		.src3 (s.b >> sh),
		.acc  (s.acc >> sh),
		.sum  (mac_sum)
	);

	assign take = issue_valid && s.issue_ready;

	// Sequencer, APB slave and result assembly
	always_comb begin
		next_s = s;
		fin = 1'b0;
		q_l = 64'h0;
		r_l = 64'h0;
		next_s.wr_valid = 1'b0;
		next_s.wr2_valid = 1'b0;
		next_s.fault_valid = 1'b0;
		next_s.div_start = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		// Setup phase prepares the answer, so the access phase has no wait
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			case (paddr)
			`DMM_A_CTRL: next_s.prdata = {30'h0, s.ctrl_sat, s.ctrl_en};
			`DMM_A_STAT: next_s.prdata = {30'h0, s.last_fault,
				s.st != DMM_IDLE};
			`DMM_A_FCNT: next_s.prdata = {16'h0, s.fault_cnt};
			default: begin
				next_s.prdata = 32'h0;
				next_s.pslverr = 1'b1;
			end
			endcase
		end
		// Writes land at the access edge only; a fault in the same cycle counts after the clear
		if (psel && penable && s.pready && pwrite && !s.pslverr) begin
			if (paddr == `DMM_A_CTRL)
				{next_s.ctrl_sat, next_s.ctrl_en} = pwdata[1:0];
			if (paddr == `DMM_A_FCNT)
				next_s.fault_cnt = 16'h0;
		end
		case (s.st)
		DMM_IDLE: if (take) begin
			next_s.ins = issue_instr;
			next_s.a = issue_src2;
			next_s.b = issue_src3;
			next_s.acc = issue_dst_val;
			next_s.k = 3'h0;
			next_s.resr = 64'h0;
			next_s.resq = 64'h0;
			case (issue_instr[`DMM_OPC_LSB +: 8])
			`DMM_OPC_MAC: begin
				// Untouched upper bits keep the old destination
				next_s.resq = issue_dst_val;
				next_s.st = DMM_MAC;
			end
			`DMM_OPC_QCONST, `DMM_OPC_MREG, `DMM_OPC_MCONST:
				next_s.st = DMM_LOAD;
			default: next_s.st = DMM_IDLE;
			endcase
		end
		DMM_LOAD: begin
			next_s.negq = na ^ nb;
			next_s.negr = na;
			next_s.satl = 1'b0;
			if (dvs_lane == 64'h0) begin
				// Saturation only rescues the remainder forms
				if (s.ctrl_sat && opc != `DMM_OPC_QCONST) begin
					next_s.satl = 1'b1;
					next_s.st = DMM_STORE;
				end else begin
					next_s.fault_valid = 1'b1;
					next_s.fault_instr = s.ins;
					next_s.last_fault = 1'b1;
					next_s.fault_cnt = next_s.fault_cnt + 16'h0001;
					next_s.st = DMM_IDLE;
				end
			end else begin
				next_s.div_start = 1'b1;
				next_s.st = DMM_DIV;
			end
		end
		DMM_DIV: if (div_done)
			next_s.st = DMM_STORE;
		DMM_STORE: begin
			// Saturated result: all-ones quotient, dividend as remainder
			q_l = s.satl ? msk : (s.negq ? ((64'h0 - div_q) & msk) : div_q);
			r_l = s.satl ? dvd_lane
				: (s.negr ? ((64'h0 - div_r) & msk) : div_r);
			next_s.resq = s.resq | (q_l << sh);
			next_s.resr = s.resr | (r_l << sh);
			fin = last;
			next_s.k = s.k + 3'h1;
			next_s.st = last ? DMM_IDLE : DMM_LOAD;
		end
		DMM_MAC: begin
			next_s.resq = (s.resq & ~(lmsk << sh)) | (mac_sum << sh);
			fin = last;
			next_s.k = s.k + 3'h1;
			next_s.st = last ? DMM_IDLE : DMM_MAC;
		end
		default: next_s.st = DMM_IDLE;
		endcase
		// Completion: remainder forms return the remainder lanes
		if (fin) begin
			next_s.wr_valid = 1'b1;
			next_s.wr_dest = s.ins[5:0];
			next_s.wr_data = (is_mac || opc == `DMM_OPC_QCONST)
				? next_s.resq : next_s.resr;
			next_s.last_fault = 1'b0;
			// Bit 20 counts only on the quotient form
			next_s.wr2_valid = opc == `DMM_OPC_QCONST
				&& s.ins[`DMM_REMF_BIT];
			next_s.wr2_dest = s.ins[5:0] + 6'h01;
			next_s.wr2_data = next_s.resr;
		end
		next_s.issue_ready = next_s.st == DMM_IDLE && next_s.ctrl_en;
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.st <= DMM_IDLE;
			{s.ctrl_sat, s.ctrl_en} <= `DMM_CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	assign issue_ready = s.issue_ready;
	assign wr_valid = s.wr_valid;
	assign wr_dest = s.wr_dest;
	assign wr_data = s.wr_data;
	assign wr2_valid = s.wr2_valid;
	assign wr2_dest = s.wr2_dest;
	assign wr2_data = s.wr2_data;
	assign fault_valid = s.fault_valid;
	assign fault_instr = s.fault_instr;
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;

	// Checks
	logic [15:0] acc16;
	logic [7:0]  a8;
	logic [7:0]  b8;
	assign acc16 = issue_dst_val[15:0];
	assign a8 = issue_src2[7:0];
	assign b8 = issue_src3[7:0];

	default clocking dmm_cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_take_mac8;
		take && issue_instr[31:24] == `DMM_OPC_MAC
			&& issue_instr[23:19] == 5'h00;
	endsequence
	sequence s_take_rem8;
		take && issue_instr[31:24] == `DMM_OPC_MREG
			&& issue_instr[23:19] == 5'h00 && issue_src2[7:0] != 8'h00;
	endsequence
	sequence s_zero_const;
		take && issue_instr[31:24] == `DMM_OPC_QCONST
			&& issue_instr[19:12] == 8'h00;
	endsequence

	a_mac_sum: assert property (s_take_mac8 |-> ##2 wr_valid
		&& wr_data[15:0] == $past(acc16, 2) + $past(a8, 2) * $past(b8, 2))
		else $error("accumulate result wrong or late");
	a_const_trap: assert property (s_zero_const |->
		##2 fault_valid && !wr_valid)
		else $error("zero constant divisor did not trap");
	a_modreg_zero: assert property (take
		&& issue_instr[31:21] == {`DMM_OPC_MREG, 3'h0}
		&& issue_src2[7:0] == 8'h00 && !s.ctrl_sat |-> ##2 fault_valid)
		else $error("zero divisor register did not fault");
	a_fault_nowrite: assert property (fault_valid |->
		!wr_valid && !wr2_valid && fault_instr == $past(s.ins))
		else $error("write not suppressed on fault");
	a_pair_write: assert property (wr2_valid |->
		wr_valid && wr2_dest == wr_dest + 6'h01)
		else $error("remainder write not paired with next register");
	a_rem8_latency: assert property (s_take_rem8 |->
		!wr_valid [*8] ##6 wr_valid)
		else $error("byte remainder latency wrong");
	a_busy_refuse: assert property (take
		&& issue_instr[31:24] inside {`DMM_OPC_QCONST, `DMM_OPC_MREG,
		`DMM_OPC_MCONST, `DMM_OPC_MAC} |=> !issue_ready)
		else $error("issue accepted while busy");
	a_apb_ready: assert property (psel && !penable && !pready |=>
		pready && $past(psel))
		else $error("apb access phase not answered");

endmodule : dmm_unit

// file: dmm_core_model.sv
module dmm_core_model (
	input  wire logic        clock,
	output logic             issue_valid,
	output logic [31:0]      issue_instr,
	output logic [63:0]      issue_src2,
	output logic [63:0]      issue_src3,
	output logic [63:0]      issue_dst_val,
	input  wire logic        issue_ready,
	input  wire logic        wr_valid,
	input  wire logic [5:0]  wr_dest,
	input  wire logic [63:0] wr_data,
	input  wire logic        wr2_valid,
	input  wire logic [5:0]  wr2_dest,
	input  wire logic [63:0] wr2_data,
	input  wire logic        fault_valid,
	input  wire logic [31:0] fault_instr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        got_wr, got_wr2, got_flt, clr;
	logic [5:0]  d1, d2;
	logic [63:0] v1, v2;
	logic [31:0] fi;
	int          lat;

	initial begin
		issue_valid = 1'b0;
		issue_instr = 32'h0;
		issue_src2 = 64'h0;
		issue_src3 = 64'h0;
		issue_dst_val = 64'h0;
		clr = 1'b0;
	end

	// Sticky capture, so a late second write is not missed
	always @(posedge clock) begin
		if (clr === 1'b1) begin
			got_wr <= 1'b0;
			got_wr2 <= 1'b0;
			got_flt <= 1'b0;
		end
		if (wr_valid === 1'b1) begin
			got_wr <= 1'b1;
			d1 <= wr_dest;
			v1 <= wr_data;
		end
		if (wr2_valid === 1'b1) begin
			got_wr2 <= 1'b1;
			d2 <= wr2_dest;
			v2 <= wr2_data;
		end
		if (fault_valid === 1'b1) begin
			got_flt <= 1'b1;
			fi <= fault_instr;
		end
	end

	// Offer one instruction, hold it until taken, then await the answer
	task automatic issue(input logic [31:0] ins,
		input logic [63:0] a, b, acc);
		int n;
		n = 0;
		@(posedge clock);
		clr <= 1'b1;
		issue_valid <= 1'b1;
		issue_instr <= ins;
		issue_src2 <= a;
		issue_src3 <= b;
		issue_dst_val <= acc;
		// Held until the edge at which ready is seen high
		do begin
			@(posedge clock);
			clr <= 1'b0;
			n++;
		end while (issue_ready !== 1'b1 && n < 5000);
		issue_valid <= 1'b0;
		// Released lines flip, so stale operands never look current
		issue_instr <= ~ins;
		issue_src2 <= ~a;
		issue_src3 <= ~b;
		issue_dst_val <= ~acc;
		lat = 0;
		// Edge first, so flags cleared at the take edge are seen cleared
		do begin
			@(posedge clock);
			lat++;
		end while (!(got_wr | got_flt) && lat < 2000);
		repeat (3) @(posedge clock);
	endtask : issue
endmodule : dmm_core_model

// file: tb_dmm_unit.sv
`include "dmm_regs.svh"

module tb_dmm_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, arst_n, issue_valid, issue_ready;
	logic        wr_valid, wr2_valid, fault_valid, e;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [5:0]  wr_dest, wr2_dest;
	logic [11:0] paddr;
	logic [31:0] issue_instr, fault_instr, pwdata, prdata, q;
	logic [63:0] issue_src2, issue_src3, issue_dst_val;
	logic [63:0] wr_data, wr2_data, x, av;
	int          failures, n_tests, lat0;

	dmm_unit dut_u (.*);
	dmm_core_model core_u (.*);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input string what, input logic [63:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; zero-wait answers still go through the pready wait
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, exp, input logic ee);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 100);
		// Answer taken and request released at the edge pready is seen
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (!wr)
			chk("prdata", exp, q);
		chk("pslverr", ee, e);
	endtask : apb

	// Lane-wise quotient or remainder; a zero divisor keeps the dividend
	function automatic logic [63:0] ref_div(input logic [1:0] sz,
		input logic simd, sgn, rem, cst, input logic [63:0] a, b);
		logic signed [64:0] x, y;
		logic [63:0]        m, r;
		int                 w;
		w = 8 << sz;
		m = (64'h1 << w) - 64'h1;
		r = 64'h0;
		for (int i = 0; i < (simd ? 64 / w : 1); i++) begin
			x = {1'b0, (a >> (i * w)) & m};
			y = cst ? {57'h0, b[7:0]} : {1'b0, (b >> (i * w)) & m};
			if (sgn && x[w - 1])
				x = x - (65'sd1 <<< w);
			if (cst ? y[7] : sgn && y[w - 1])
				y = y - (cst ? 65'sd256 : (65'sd1 <<< w));
			x = (y == 0) ? x : (rem ? x % y : x / y);
			r = r | ((x[63:0] & m) << (i * w));
		end
		return r;
	endfunction : ref_div

	// Accumulate into lanes twice the source width, 64 bits at most; wraps on overflow
	function automatic logic [63:0] ref_mac(input logic [1:0] sz,
		input logic simd, hi, sgn, input logic [63:0] a, b, acc);
		logic signed [64:0] x, y;
		logic [63:0]        m, md, r;
		int                 w, dl, o;
		w = 8 << sz;
		dl = (sz == 2'h3) ? 64 : 2 * w;
		m = (64'h1 << w) - 64'h1;
		md = (64'h1 << dl) - 64'h1;
		o = (simd && hi && sz != 2'h3) ? w : 0;
		r = simd ? 64'h0 : acc & ~md;
		for (int i = 0; i < (simd ? 64 / dl : 1); i++) begin
			x = {1'b0, (a >> (i * dl + o)) & m};
			y = {1'b0, (b >> (i * dl + o)) & m};
			if (sgn && x[w - 1])
				x = x - (65'sd1 <<< w);
			if (sgn && y[w - 1])
				y = y - (65'sd1 <<< w);
			x = x * y + {1'b0, (acc >> (i * dl)) & md};
			r = r | ((x[63:0] & md) << (i * dl));
		end
		return r;
	endfunction : ref_mac

	// Issue, then compare either the write or the fault report
	task automatic dcase(input logic [31:0] i, input logic [63:0] s2, s3,
		exp, input logic flt);
		core_u.issue(i, s2, s3, av);
		chk("fault", flt, core_u.got_flt);
		chk("write", !flt, core_u.got_wr);
		if (flt)
			chk("fault word", i, core_u.fi);
		else begin
			chk("dest", i[5:0], core_u.d1);
			chk("data", exp, core_u.v1);
		end
	endtask : dcase

	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	// Watchdog well beyond the several hundred cycles the tests need
	initial begin
		#1000000;
		failures++;
		print_verdict;
	end

	initial begin
		failures = 0;
		n_tests = 0;
		av = 64'h0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		apb(0, `DMM_A_CTRL, 0, 32'h1, 0);
		apb(0, 12'h00C, 0, 32'h0, 1);
		apb(1, 12'h010, 32'h3, 0, 1);
		apb(0, `DMM_A_CTRL, 0, 32'h1, 0);
		$display("Test registers done");
		for (int s = 0; s < 4; s++) begin
			x = ref_div(s[1:0], 0, 1, 0, 1, 64'd100, 64'hF9);
			dcase({`DMM_OPC_QCONST, s[1:0], 2'b00, 8'hF9, 12'h085},
				64'd100, 0, x, 0);
			if (s == 0)
				lat0 = core_u.lat;
		end
		chk("latency", 1, core_u.lat > lat0);
		x = ref_div(0, 0, 1, 0, 1, 64'd100, 64'h07);
		dcase({`DMM_OPC_QCONST, 4'h1, 8'h07, 12'h0BF}, 64'd100, 0, x, 0);
		chk("second write", 1, core_u.got_wr2);
		chk("second dest", 0, core_u.d2);
		x = ref_div(0, 0, 1, 1, 1, 64'd100, 64'h07);
		chk("remainder", x, core_u.v2);
		dcase({`DMM_OPC_QCONST, 4'h0, 8'h00, 12'h085}, 9, 0, 0, 1);
		dcase({`DMM_OPC_MCONST, 4'h0, 8'h00, 12'h085}, 9, 0, 0, 1);
		x = ref_div(1, 0, 1, 1, 1, 64'hFF9C, 64'h07);
		dcase({`DMM_OPC_MCONST, 4'h4, 8'h07, 12'h085},
			64'hFF9C, 0, x, 0);
		$display("Test constant forms done");
		for (int k = 0; k < 4; k++) begin
			x = ref_div(0, 0, k[0], 1, 0, 64'hF0, 64'h07);
			dcase({`DMM_OPC_MREG, 3'h0, k[1], k[0], k[1], 18'h00C85},
				64'h07, 64'hF0, x, 0);
		end
		x = ref_div(0, 1, 0, 1, 0, 64'hC864_503C_281E_140A,
			64'h0905_0703_0307_0503);
		dcase({`DMM_OPC_MREG, 6'h08, 18'h00C85}, 64'h0905_0703_0307_0503,
			64'hC864_503C_281E_140A, x, 0);
		dcase({`DMM_OPC_MREG, 6'h08, 18'h00C85}, 64'h0905_0003_0307_0503,
			64'hC864_503C_281E_140A, 0, 1);
		apb(0, `DMM_A_STAT, 0, 32'h2, 0);
		apb(0, `DMM_A_FCNT, 0, 32'h3, 0);
		apb(1, `DMM_A_FCNT, 32'h0, 0, 0);
		apb(0, `DMM_A_FCNT, 0, 32'h0, 0);
		apb(1, `DMM_A_CTRL, 32'h3, 0, 0);
		x = ref_div(0, 1, 0, 1, 0, 64'hC864_503C_281E_140A,
			64'h0905_0003_0307_0503);
		dcase({`DMM_OPC_MREG, 6'h08, 18'h00C85}, 64'h0905_0003_0307_0503,
			64'hC864_503C_281E_140A, x, 0);
		apb(1, `DMM_A_CTRL, 32'h0, 0, 0);
		repeat (2) @(negedge clock);
		chk("ready while disabled", 0, issue_ready);
		apb(1, `DMM_A_CTRL, 32'h1, 0, 0);
		dcase({`DMM_OPC_MREG, 6'h00, 18'h00C85}, 64'h0,
			64'hF0, 0, 1);
		$display("Test register modulo done");
		// Small accumulator keeps every lane clear of overflow
		av = 64'h0010_0020_0030_0040;
		for (int k = 0; k < 5; k++) begin
			x = ref_mac(0, k < 4, k[1], k[0], 64'h7F05_FE03_8102_1004,
				64'h0203_0405_0607_0809, av);
			dcase({`DMM_OPC_MAC, 2'b00, k < 4, 1'b0, k[0], k[1],
				18'h00C85}, 64'h7F05_FE03_8102_1004,
				64'h0203_0405_0607_0809, x, 0);
		end
		$display("Test accumulate done");
		print_verdict;
	end
endmodule : tb_dmm_unit
